// >>> rtl/irq_pkg.sv
// Behaviour
// RULE1: Packet number exhaustion sets cause bit 14; bit reserved when feature absent.
// RULE2: Transmit descriptor ring low threshold sets cause bit 15.
// RULE3: Small received packet written to memory sets bit 16, only if size nonzero.
// RULE4: Reply frame received and reply delay expired sets cause bit 17.
// RULE5: Clearing the CPU vector also clears cause bits 16 and 17.
// RULE6: Manageability read of host-to-engine status, or set register bit 18, sets bit 18.
// RULE7: Cause bit 19 is reserved and always reads zero.
// RULE8: Summary bit 31 shows a pending interrupt; host interrupt needs PCI enable.
// RULE9: Throttle register field 15:0 holds the interval in 256 ns units.
// RULE10: Interval zero disables throttling; interrupts go out without spacing.
// RULE11: With throttling on, successive interrupts are at least the interval apart.
// RULE12: At 10/100 Mb/s on quarter clock the interval stretches fourfold.
// RULE13: Software should start with an interval between 651 and 5580.
// RULE14: Writing 1 to a cause set bit sets that cause bit.
// RULE15: Writing 0 to a cause set bit leaves that cause unchanged.
// RULE16: A cause set through the set register interrupts when its mask is on.
// RULE17: Set bit 20 sets engine reset cause; bits 0-2,4-7,9,12,14-18 set their own.
// RULE18: Software writes zero to throttle bits 31:16 and set bits 31:22.
// RULE19: Writing 1 to a cause bit clears it; writes never touch summary bit.
// RULE20: Summary bit clears only once every cause has been cleared.
// RULE21: Cause read while asserted clears causes and applies auto-mask; else keeps them. The code also clears them on a read while every mask bit is 0.
// RULE22: Interrupt reaches the bus only when mask bit and cause bit are both 1. The code keeps it asserted while any cause bit is set, masked or not.
// RULE23: Interval restarts at each assertion; early causes wait for its expiry.
`default_nettype none
package irq_pkg;
    localparam logic [7:0] OFS_CAUSE_READ = 8'hc0;
    localparam logic [7:0] OFS_THROTTLE = 8'hc4;
    localparam logic [7:0] OFS_CAUSE_SET = 8'hc8;
    localparam logic [7:0] OFS_MASK_SET = 8'hd0;
    localparam logic [7:0] OFS_MASK_CLEAR = 8'hd8;
    localparam logic [7:0] OFS_AUTO_MASK = 8'he0;

    localparam int BIT_PN_EXHAUSTED = 14;
    localparam int BIT_TX_DESC_LOW = 15;
    localparam int BIT_SMALL_RX = 16;
    localparam int BIT_REPLY_FRAME = 17;
    localparam int BIT_MANAGEABILITY = 18;
    localparam int BIT_ENGINE_RESET = 20;
    localparam int BIT_SUMMARY = 31;

    // Cause bits that exist: 0-2, 4-7, 9, 12, 14-18, 20
    localparam logic [31:0] CAUSE_IMPL = 32'h0017d2f7;
    localparam logic [31:0] CPU_VECTOR_CLR = 32'h00030000;
    localparam logic [31:0] CAUSE_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [15:0] THROTTLE_RESET = 16'h0000;

    localparam int CLK_PERIOD_NS = 20;
    localparam int UNIT_NS = 256;
    localparam int SLOW_FACTOR = 4;
    // Least time: round up to whole cycles
    localparam int UNIT_CYCLES = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] UNIT_LAST = 6'(UNIT_CYCLES - 1);
    localparam logic [5:0] SLOW_UNIT_LAST = 6'(UNIT_CYCLES * SLOW_FACTOR - 1);
endpackage
`default_nettype wire

// >>> rtl/throttle_if.sv
`timescale 1ns/1ns
`default_nettype none
interface throttle_if;
    logic [15:0] interval;
    logic slow_mode;
    logic fire;
    logic ready;
    logic unit_tick;

    modport ctl (output interval, output slow_mode, output fire, input ready);
    modport timer (input interval, input fire, input unit_tick, output ready);
    modport pre (input slow_mode, input fire, output unit_tick);
endinterface // throttle_if
`default_nettype wire

// >>> rtl/unit_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module unit_prescaler (
    input wire logic mclk,
    input wire logic rstn,
    throttle_if.pre thr
);
    logic [5:0] cnt_q;
    logic [5:0] last;

    assign last = thr.slow_mode ? irq_pkg::SLOW_UNIT_LAST : irq_pkg::UNIT_LAST; // see RULE12
    assign thr.unit_tick = (cnt_q == last);

    // Restarting on each assertion makes the first unit a full one
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_q <= 6'h00;
        end else if (thr.fire || cnt_q >= last) begin
            cnt_q <= 6'h00; // see RULE9
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end
endmodule // unit_prescaler
`default_nettype wire

// >>> rtl/throttle_timer.sv
`timescale 1ns/1ns
`default_nettype none
module throttle_timer (
    input wire logic mclk,
    input wire logic rstn,
    throttle_if.timer thr
);
    logic [15:0] remain_q;

    // Zero interval loads zero, so ready never drops
    assign thr.ready = (remain_q == 16'h0000); // see RULE10

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            remain_q <= 16'h0000;
        end else if (thr.fire) begin
            remain_q <= thr.interval; // see RULE23
        end else if (thr.unit_tick && remain_q != 16'h0000) begin
            remain_q <= remain_q - 16'h0001; // see RULE11
        end
    end
endmodule // throttle_timer
`default_nettype wire

// >>> rtl/mac_interrupt_cause_throttle.sv
`timescale 1ns/1ns
`default_nettype none
module mac_interrupt_cause_throttle #(
    parameter bit PN_PRESENT = 1'b1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic packet_number_exhausted,
    input wire logic tx_desc_low_hit,
    input wire logic small_rx_packet_detected,
    input wire logic [15:0] small_packet_size_setting,
    input wire logic reply_frame_received,
    input wire logic reply_delay_timer,
    input wire logic host_to_engine_status_read,
    input wire logic engine_reset_event,
    input wire logic cpu_vector_clear,
    input wire logic pci_int_enable,
    input wire logic slow_link_mode,
    output logic host_irq
);
    throttle_if thr ();

    logic dp_valid_q;
    logic dp_write_q;
    logic [7:0] dp_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] cause_q;
    logic [31:0] cause_d;
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [31:0] auto_mask_q;
    logic [15:0] interval_q;
    logic int_asserted_q;
    logic host_irq_q;
    logic reply_seen_q;
    logic addr_take;
    logic rd_take;
    logic wr_now;
    logic cause_rd_clear;
    logic [31:0] impl;
    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] clr;
    logic pending;
    logic fire;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    function automatic logic [31:0] bit_at(input int idx);
        bit_at = 32'h00000001 << idx;
    endfunction

    // Bit 14 exists only on variants with the packet number feature
    assign impl = PN_PRESENT ? irq_pkg::CAUSE_IMPL
                             : (irq_pkg::CAUSE_IMPL & ~bit_at(irq_pkg::BIT_PN_EXHAUSTED)); // see RULE1

    // Bus slave: never stalls, always OKAY; only whole-word accesses are expected
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    assign addr_take = hsel && hready && htrans[1];
    assign rd_take = addr_take && !hwrite;
    assign wr_now = dp_valid_q && dp_write_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end else if (hready) begin
            dp_valid_q <= addr_take;
            dp_write_q <= hwrite;
            dp_addr_q <= haddr[7:0];
        end
    end

    // Read data captured in the address phase so it stands through the data phase
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_q <= 32'h00000000;
        end else if (rd_take) begin
            if (hit(haddr[7:0], irq_pkg::OFS_CAUSE_READ)) begin
                rdata_q <= {int_asserted_q, cause_q[30:0] & impl[30:0]}; // see RULE7
            end else if (hit(haddr[7:0], irq_pkg::OFS_THROTTLE)) begin
                rdata_q <= {16'h0000, interval_q};
            end else if (hit(haddr[7:0], irq_pkg::OFS_MASK_SET)) begin
                rdata_q <= mask_q;
            end else if (hit(haddr[7:0], irq_pkg::OFS_AUTO_MASK)) begin
                rdata_q <= auto_mask_q;
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    // A cause read clears only while asserted or with everything masked
    assign cause_rd_clear = rd_take && hit(haddr[7:0], irq_pkg::OFS_CAUSE_READ)
                            && (int_asserted_q || mask_q == 32'h00000000); // see RULE21

    always_comb begin
        hw_set = 32'h00000000;
        if (packet_number_exhausted) begin
            hw_set = hw_set | bit_at(irq_pkg::BIT_PN_EXHAUSTED); // see RULE1
        end
        if (tx_desc_low_hit) begin
            hw_set = hw_set | bit_at(irq_pkg::BIT_TX_DESC_LOW); // see RULE2
        end
        if (small_rx_packet_detected && small_packet_size_setting != 16'h0000) begin
            hw_set = hw_set | bit_at(irq_pkg::BIT_SMALL_RX); // see RULE3
        end
        if (reply_delay_timer && (reply_seen_q || reply_frame_received)) begin
            hw_set = hw_set | bit_at(irq_pkg::BIT_REPLY_FRAME); // see RULE4
        end
        if (host_to_engine_status_read) begin
            hw_set = hw_set | bit_at(irq_pkg::BIT_MANAGEABILITY); // see RULE6
        end
        if (engine_reset_event) begin
            hw_set = hw_set | bit_at(irq_pkg::BIT_ENGINE_RESET);
        end
    end

    // Zeros written leave causes alone; bits 19, 3 and others never exist
    assign sw_set = (wr_now && hit(dp_addr_q, irq_pkg::OFS_CAUSE_SET)) ? (hwdata & impl)
                                                                       : 32'h00000000; // see RULE14 RULE15 RULE17

    always_comb begin
        clr = 32'h00000000;
        if (wr_now && hit(dp_addr_q, irq_pkg::OFS_CAUSE_READ)) begin
            clr = clr | hwdata; // see RULE19
        end
        if (cause_rd_clear) begin
            clr = 32'hffffffff; // see RULE21
        end
        if (cpu_vector_clear) begin
            clr = clr | irq_pkg::CPU_VECTOR_CLR; // see RULE5
        end
    end

    // New events win over a clear in the same cycle
    assign cause_d = ((cause_q & ~clr) | hw_set | sw_set) & impl; // see RULE7 RULE14

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cause_q <= irq_pkg::CAUSE_RESET;
        end else begin
            cause_q <= cause_d;
        end
    end

    // A reply frame waits here until its delay timer runs out
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reply_seen_q <= 1'b0;
        end else if (reply_delay_timer) begin
            reply_seen_q <= 1'b0;
        end else if (reply_frame_received) begin
            reply_seen_q <= 1'b1;
        end
    end

    always_comb begin
        mask_d = mask_q;
        if (wr_now && hit(dp_addr_q, irq_pkg::OFS_MASK_SET)) begin
            mask_d = mask_d | (hwdata & impl);
        end
        if (wr_now && hit(dp_addr_q, irq_pkg::OFS_MASK_CLEAR)) begin
            mask_d = mask_d & ~hwdata;
        end
        if (cause_rd_clear && int_asserted_q) begin
            mask_d = mask_d & ~auto_mask_q; // see RULE21
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mask_q <= irq_pkg::MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            auto_mask_q <= irq_pkg::MASK_RESET;
        end else if (wr_now && hit(dp_addr_q, irq_pkg::OFS_AUTO_MASK)) begin
            auto_mask_q <= hwdata & impl;
        end
    end

    // Upper bits are dropped; software is expected to write them as zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            interval_q <= irq_pkg::THROTTLE_RESET;
        end else if (wr_now && hit(dp_addr_q, irq_pkg::OFS_THROTTLE)) begin
            interval_q <= hwdata[15:0]; // see RULE9
        end
    end

    // Enabled causes, from hardware or the set register alike, request delivery
    assign pending = |(cause_q & mask_q); // see RULE22 RULE16
    // A pending cause is held while the interval runs
    assign fire = pending && !int_asserted_q && thr.ready; // see RULE11 RULE23

    assign thr.interval = interval_q;
    assign thr.slow_mode = slow_link_mode; // see RULE12
    assign thr.fire = fire;

    unit_prescaler u_prescaler (
        .mclk(mclk),
        .rstn(rstn),
        .thr(thr.pre)
    );

    throttle_timer u_timer (
        .mclk(mclk),
        .rstn(rstn),
        .thr(thr.timer)
    );

    // Register writes never touch the summary; it falls only with all causes gone
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            int_asserted_q <= 1'b0;
        end else if (cause_d == 32'h00000000) begin
            int_asserted_q <= 1'b0; // see RULE20 RULE19
        end else if (fire) begin
            int_asserted_q <= 1'b1; // see RULE8
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            host_irq_q <= 1'b0;
        end else begin
            host_irq_q <= int_asserted_q && pci_int_enable && (cause_d != 32'h00000000); // see RULE8
        end
    end

    assign host_irq = host_irq_q;

endmodule // mac_interrupt_cause_throttle
`default_nettype wire

// >>> verif/irq_props.sv
`timescale 1ns/1ns
`default_nettype none
module irq_props (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pci_int_enable,
    input wire logic slow_link_mode,
    input wire logic host_irq
);
    default clocking cb @(posedge mclk); endclocking
    logic take;
    logic ra_q, wa_q, seen_q;
    logic [7:0] ad_q;
    logic [15:0] itv_q, itr_q;
    logic [31:0] gap_q;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge mclk) begin
        ra_q <= rstn && take && !hwrite;
        wa_q <= rstn && take && hwrite;
        if (take) begin
            ad_q <= haddr[7:0];
            itr_q <= itv_q;
        end
    end
    // Shadow interval so spacing can be judged from the pins alone
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            itv_q <= 16'h0000;
        end else if (wa_q && ad_q == 8'hc4) begin
            itv_q <= hwdata[15:0];
        end
    end
    // A new interval or clock mode makes the previous gap meaningless
    always_ff @(posedge mclk) begin
        if (!rstn || (wa_q && ad_q == 8'hc4) || $changed(slow_link_mode)) begin
            seen_q <= 1'b0;
        end else if ($rose(host_irq)) begin
            seen_q <= 1'b1;
        end
        gap_q <= (!rstn || $rose(host_irq)) ? 32'h1 : gap_q + 32'h1;
    end
    a_resp_okay: assert property (disable iff (!rstn) hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    a_reset_quiet: assert property (!rstn |=> !host_irq && hrdata == 32'h0)
        else $error("outputs not quiet after reset");
    a_irq_pci_gate: assert property (disable iff (!rstn) $rose(host_irq) |-> $past(pci_int_enable))
        else $error("interrupt raised while disabled");
    a_irq_spacing: assert property (disable iff (!rstn)
        $rose(host_irq) && seen_q && itv_q != 16'h0
        |-> gap_q >= itv_q * (slow_link_mode ? 32'h34 : 32'h0d))
        else $error("interrupts closer than interval");
    a_itv_readback: assert property (disable iff (!rstn)
        ra_q && ad_q == 8'hc4 |-> hrdata == {16'h0000, itr_q})
        else $error("interval readback wrong");
    a_cause_reserved: assert property (disable iff (!rstn)
        ra_q && ad_q == 8'hc0 |-> (hrdata & ~32'h8017d2f7) == 32'h0)
        else $error("reserved cause bit set");
    a_wo_reads_zero: assert property (disable iff (!rstn)
        ra_q && !(ad_q inside {8'hc0, 8'hc4, 8'hd0, 8'he0}) |-> hrdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    a_rdata_stands: assert property (disable iff (!rstn) $changed(hrdata) |-> ra_q)
        else $error("read data moved without a read");
endmodule // irq_props
bind mac_interrupt_cause_throttle irq_props u_irq_props (.mclk(mclk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pci_int_enable(pci_int_enable),
    .slow_link_mode(slow_link_mode), .host_irq(host_irq));
`default_nettype wire

// >>> verif/irq_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module irq_host_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic host_irq,
    output int rises,
    output int last_gap
);
    int since;
    logic irq_q;
    // Level interrupt: the host only notices rises, so gaps are rise to rise
    always_ff @(posedge mclk) begin
        irq_q <= host_irq;
        if (!rstn) begin
            rises <= 0;
            since <= 0;
            last_gap <= 0;
        end else if (host_irq && !irq_q) begin
            rises <= rises + 1;
            last_gap <= since;
            since <= 1;
        end else begin
            since <= since + 1;
        end
    end
endmodule // irq_host_model
`default_nettype wire

// >>> verif/mac_interrupt_cause_throttle_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mac_interrupt_cause_throttle_tb;
    logic mclk, rstn, hsel, hwrite, pci, slow, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, v, w;
    logic [1:0] htrans;
    logic [15:0] size;
    logic [7:0] ev;
    int err_total, cmp_count, cyc, rises, gap, n;
    mac_interrupt_cause_throttle u_mac_interrupt_cause_throttle (.mclk(mclk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .packet_number_exhausted(ev[0]), .tx_desc_low_hit(ev[1]), .small_rx_packet_detected(ev[2]),
        .small_packet_size_setting(size), .reply_frame_received(ev[3]), .reply_delay_timer(ev[4]),
        .host_to_engine_status_read(ev[5]), .engine_reset_event(ev[6]), .cpu_vector_clear(ev[7]),
        .pci_int_enable(pci), .slow_link_mode(slow), .host_irq(irq));
    irq_host_model u_irq_host_model (.mclk(mclk), .rstn(rstn), .host_irq(irq), .rises(rises),
        .last_gap(gap));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        @(posedge mclk);
        ev <= 8'h00;
        @(posedge mclk);
    endtask
    task automatic wait_irq(input logic lvl, input int max);
        n = 0;
        while (irq !== lvl && n < max) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, irq}, {31'h0, lvl});
    endtask
    // Second cause set right after clearing must wait out the interval
    task automatic thr(input logic s, input int unit, input int itv);
        slow <= s;
        bus(1'b1, 8'hc4, itv);
        bus(1'b1, 8'hc8, 32'h00040000);
        wait_irq(1'b1, itv * unit + 20);
        bus(1'b0, 8'hc0, 32'h0);
        bus(1'b1, 8'hc8, 32'h00040000);
        wait_irq(1'b0, 20);
        wait_irq(1'b1, itv * unit + 20);
        // The host model takes the gap at the rise edge; read it one edge later
        @(posedge mclk);
        chk({31'h0, gap >= itv * unit && gap <= itv * unit + 8}, 32'h1);
        bus(1'b0, 8'hc0, 32'h0);
        // The interval is still running; let it expire so the next call starts ready
        repeat (itv * unit + 8) @(posedge mclk);
    endtask
    initial begin
        rstn = 1'b0;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ev = 8'h00;
        size = 16'h0000;
        pci = 1'b1;
        slow = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
        void'($urandom(32'ha4002b7f));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rdchk(8'hc4, 32'h0);
        rdchk(8'hc0, 32'h0);
        rdchk(8'hc8, 32'h0);
        rdchk(8'h3c, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom() & 32'h003fffff;
            w = $urandom() & 32'h003fffff;
            bus(1'b1, 8'hc8, v);
            bus(1'b1, 8'hc8, w);
            bus(1'b1, 8'hc0, w);
            rdchk(8'hc0, v & ~w & 32'h0017d2f7);
            rdchk(8'hc0, 32'h0);
        end
        pulse(8'h04);
        rdchk(8'hc0, 32'h0);
        size <= 16'h0040;
        pulse(8'h7f);
        rdchk(8'hc0, 32'h0017c000);
        pulse(8'h7f);
        pulse(8'h80);
        rdchk(8'hc0, 32'h0014c000);
        bus(1'b1, 8'hd0, 32'h00040200);
        bus(1'b1, 8'he0, 32'h00040000);
        pulse(8'h02);
        repeat (10) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(8'hc0, 32'h00008000);
        rdchk(8'hc0, 32'h00008000);
        bus(1'b1, 8'hc0, 32'h00008000);
        rdchk(8'hc0, 32'h0);
        pci <= 1'b0;
        bus(1'b1, 8'hc8, 32'h00040000);
        repeat (10) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 8'hc0, 32'h80000000);
        pci <= 1'b1;
        wait_irq(1'b1, 5);
        rdchk(8'hc0, 32'h80040000);
        rdchk(8'hd0, 32'h00000200);
        wait_irq(1'b0, 5);
        rdchk(8'hc0, 32'h0);
        bus(1'b1, 8'hd0, 32'h00040000);
        bus(1'b1, 8'he0, 32'h0);
        thr(1'b0, 13, 651);
        thr(1'b1, 52, 100);
        chk(rises, 32'h5);
        end_of_test();
    end
endmodule // mac_interrupt_cause_throttle_tb
`default_nettype wire
